// file: logic/act_cal_top.sv
// per-stage ambient tracking, offset calibration and adaptive trip levels
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module act_cal_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic [act_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic convValid,
  input wire logic [act_pkg::STAGE_W-1:0] convStage,
  input wire logic [act_pkg::DW-1:0] convData,
  input wire logic proximity,
  output logic [act_pkg::STAGES-1:0] stageActive
);
  import act_pkg::*;

  act_reg_if rb();

  act_bus uBus (
    .clk(clk),
    .srst(srst),
    .address(avs_address),
    .read(avs_read),
    .write(avs_write),
    .writedata(avs_writedata),
    .byteenable(avs_byteenable),
    .readdata(avs_readdata),
    .waitrequest(avs_waitrequest),
    .rb(rb)
  );

  logic [DW-1:0] ctrlReg;
  logic [DW-1:0] skipReg;
  logic [DW-1:0] pushReg;
  logic [DW-1:0] statusReg;
  logic [DW-1:0] ambient [STAGES];
  logic signed [DW-1:0] upperOfs [STAGES];
  logic signed [DW-1:0] lowerOfs [STAGES];
  logic [DW-1:0] sensCfg [STAGES];
  logic [DW-1:0] upperTrip [STAGES];
  logic [DW-1:0] lowerTrip [STAGES];
  logic [DW-1:0] avgMax [STAGES];
  logic [DW-1:0] avgMin [STAGES];
  logic [DW-1:0] lastPush [STAGES];
  logic [DW-1:0] slowFifo [STAGES][SLOW_DEPTH];
  logic [SKIP_CNT_W-1:0] skipCnt [STAGES];
  logic [STAGES-1:0] touched;
  logic [STAGES-1:0] dirty;

  function automatic logic [DW-1:0] mergeBytes(input logic [DW-1:0] old,
                                               input logic [DW-1:0] nw,
                                               input logic [1:0] be);
    return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  // conversions of one stage between slow FIFO samples
  function automatic logic [SKIP_CNT_W-1:0] slowPeriod(input logic lp,
                                                       input logic [1:0] fp,
                                                       input logic [1:0] lps,
                                                       input logic [3:0] ff,
                                                       input logic [1:0] dly);
    logic [SKIP_CNT_W-1:0] num;
    logic [SKIP_CNT_W-1:0] den;
    logic [SKIP_CNT_W-1:0] q;
    num = '0;
    den = '0;
    q = '0;
    if (!lp) begin
      // a zero skip would mean no period at all; treat it as one
      num = SKIP_CNT_W'((fp == 2'h0) ? 2'h1 : fp) * (SKIP_CNT_W'(ff) + 8'h01);
      return num;
    end
    num = (SKIP_CNT_W'(lps) + 8'h01) * (SKIP_CNT_W'(ff) + 8'h01);
    den = SKIP_CNT_W'(ff) + 8'h01 + SKIP_CNT_W'(dly);
    q = num / den;
    return (q == '0) ? 8'h01 : q;
  endfunction

  function automatic logic [STAGE_W-1:0] firstSet(input logic [STAGES-1:0] v);
    logic [STAGE_W-1:0] r;
    r = '0;
    for (int i = STAGES - 1; i >= 0; i--) begin
      if (v[i]) r = STAGE_W'(i);
    end
    return r;
  endfunction

  // register access decode
  logic wrEn;
  logic stageWr;
  logic [STAGE_W-1:0] ws;
  logic [2:0] wslot;
  logic [DW-1:0] rdMux;

  assign wrEn = rb.go & rb.we;
  assign stageWr = wrEn & (rb.idx >= IDX_STAGE_BASE);
  assign ws = rb.idx[5:3];
  assign wslot = rb.idx[2:0];
  assign rb.rdata = rdMux;

  always_comb begin
    rdMux = '0;
    if (rb.idx >= IDX_STAGE_BASE) begin
      case (rb.idx[2:0])
        SLOT_UPPER_OFS: rdMux = upperOfs[rb.idx[5:3]];
        SLOT_LOWER_OFS: rdMux = lowerOfs[rb.idx[5:3]];
        SLOT_SENS: rdMux = sensCfg[rb.idx[5:3]];
        SLOT_AMBIENT: rdMux = ambient[rb.idx[5:3]];
        SLOT_UPPER_TRIP: rdMux = upperTrip[rb.idx[5:3]];
        SLOT_LOWER_TRIP: rdMux = lowerTrip[rb.idx[5:3]];
        SLOT_AVG_MAX: rdMux = avgMax[rb.idx[5:3]];
        default: rdMux = avgMin[rb.idx[5:3]];
      endcase
    end else begin
      case (rb.idx)
        IDX_CTRL: rdMux = ctrlReg;
        IDX_SKIP: rdMux = skipReg;
        IDX_PUSH: rdMux = pushReg;
        IDX_STATUS: rdMux = statusReg;
        default: rdMux = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrlReg <= CTRL_RST;
      skipReg <= SKIP_RST;
      pushReg <= PUSH_RST;
    end else if (wrEn) begin
      case (rb.idx)
        IDX_CTRL: ctrlReg <= mergeBytes(ctrlReg, rb.wdata, rb.be);
        IDX_SKIP: skipReg <= mergeBytes(skipReg, rb.wdata, rb.be);
        IDX_PUSH: pushReg <= mergeBytes(pushReg, rb.wdata, rb.be);
        default: ;
      endcase
    end
  end

  // stage one: ambient, offsets and averages of the stage just converted
  logic p1Valid;
  logic [STAGE_W-1:0] p1Stage;
  logic [DW-1:0] p1Data;
  logic [SKIP_CNT_W-1:0] period;
  logic skipHit;
  logic allowCal;
  logic doPush;
  logic [DW-1:0] pushDiff;
  logic [DW-1:0] newAmb;
  logic [DW+SLOW_DEPTH_LOG-1:0] fifoSum;
  logic signed [CW-1:0] drift;
  logic signed [CW-1:0] sData;
  logic signed [CW-1:0] sAmb;
  logic signed [CW-1:0] sMax;
  logic signed [CW-1:0] sMin;
  logic signed [CW-1:0] maxWin;
  logic signed [CW-1:0] minWin;
  logic signed [CW-1:0] newMax;
  logic signed [CW-1:0] newMin;
  logic nearMax;
  logic nearMin;

  always_ff @(posedge clk) begin
    if (srst) begin
      p1Valid <= 1'b0;
      p1Stage <= '0;
      p1Data <= '0;
    end else begin
      p1Valid <= convValid;
      p1Stage <= convStage;
      p1Data <= convData;
    end
  end

  always_comb begin
    period = slowPeriod(ctrlReg[CTRL_LP_BIT], skipReg[SKIP_FP_LSB +: 2],
                        skipReg[SKIP_LP_LSB +: 2], ctrlReg[CTRL_FF_LSB +: 4],
                        ctrlReg[CTRL_DLY_LSB +: 2]);
    skipHit = (skipCnt[p1Stage] >= period - 8'h01);
    allowCal = ctrlReg[CTRL_SFEN_BIT] & ~proximity & ~touched[p1Stage];
    pushDiff = (p1Data > lastPush[p1Stage]) ? p1Data - lastPush[p1Stage]
                                            : lastPush[p1Stage] - p1Data;
    doPush = p1Valid & allowCal & skipHit
           & (pushDiff > DW'(pushReg[PUSH_LVL_LSB +: 2]));
    fifoSum = (DW + SLOW_DEPTH_LOG)'(p1Data);
    for (int k = 0; k < SLOW_DEPTH - 1; k++) begin
      fifoSum = fifoSum + (DW + SLOW_DEPTH_LOG)'(slowFifo[p1Stage][k]);
    end
    newAmb = fifoSum[DW+SLOW_DEPTH_LOG-1:SLOW_DEPTH_LOG];
    sData = CW'(p1Data);
    sAmb = CW'(ambient[p1Stage]);
    drift = CW'(newAmb) - sAmb;
    sMax = CW'(avgMax[p1Stage]);
    sMin = CW'(avgMin[p1Stage]);
    maxWin = act_div_pow2(CW'((sMax - sAmb) * CW'(sensCfg[p1Stage][SENS_PPK_LSB +: 4])),
                          PEAK_SH);
    minWin = act_div_pow2(CW'((sAmb - sMin) * CW'(sensCfg[p1Stage][SENS_NPK_LSB +: 4])),
                          PEAK_SH);
    nearMax = p1Valid & ~doPush & (sData > sAmb) & (sData > sMax - maxWin);
    nearMin = p1Valid & ~doPush & (sData < sAmb) & (sData < sMin + minWin);
    newMax = sMax + act_div_pow2(sData - sMax, AVG_SH);
    newMin = sMin + act_div_pow2(sData - sMin, AVG_SH);
  end

  // only index p1Stage is touched by hardware; software writes override last
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int s = 0; s < STAGES; s++) begin
        ambient[s] <= '0;
        upperOfs[s] <= '0;
        lowerOfs[s] <= '0;
        sensCfg[s] <= SENS_RST;
        avgMax[s] <= '0;
        avgMin[s] <= '0;
        lastPush[s] <= '0;
        skipCnt[s] <= '0;
        for (int k = 0; k < SLOW_DEPTH; k++) begin
          slowFifo[s][k] <= '0;
        end
      end
    end else begin
      if (p1Valid) begin
        skipCnt[p1Stage] <= skipHit ? '0 : skipCnt[p1Stage] + 8'h01;
      end
      if (doPush) begin
        slowFifo[p1Stage][0] <= p1Data;
        for (int k = 1; k < SLOW_DEPTH; k++) begin
          slowFifo[p1Stage][k] <= slowFifo[p1Stage][k-1];
        end
        lastPush[p1Stage] <= p1Data;
        ambient[p1Stage] <= newAmb;
        upperOfs[p1Stage] <= act_sat_s16(CW'(upperOfs[p1Stage]) - drift);
        lowerOfs[p1Stage] <= act_sat_s16(CW'(lowerOfs[p1Stage]) - drift);
      end
      if (nearMax) begin
        avgMax[p1Stage] <= act_sat_u16(newMax);
        upperOfs[p1Stage] <= act_sat_s16(newMax - sAmb);
      end
      if (nearMin) begin
        avgMin[p1Stage] <= act_sat_u16(newMin);
        lowerOfs[p1Stage] <= act_sat_s16(newMin - sAmb);
      end
      if (stageWr) begin
        case (wslot)
          SLOT_UPPER_OFS: begin
            upperOfs[ws] <= mergeBytes(upperOfs[ws], rb.wdata, rb.be);
            avgMax[ws] <= act_sat_u16(CW'(ambient[ws]) + CW'($signed(rb.wdata)));
          end
          SLOT_LOWER_OFS: begin
            lowerOfs[ws] <= mergeBytes(lowerOfs[ws], rb.wdata, rb.be);
            avgMin[ws] <= act_sat_u16(CW'(ambient[ws]) + CW'($signed(rb.wdata)));
          end
          SLOT_SENS: sensCfg[ws] <= mergeBytes(sensCfg[ws], rb.wdata, rb.be);
          default: ;
        endcase
      end
    end
  end

  // stage two: trip recompute and comparison
  logic p2Valid;
  logic [STAGE_W-1:0] p2Stage;
  logic [DW-1:0] p2Data;
  logic [STAGE_W-1:0] trSel;
  logic [DW-1:0] newUpper;
  logic [DW-1:0] newLower;
  logic hitHigh;
  logic hitLow;
  logic [STAGES-1:0] dirtySet;
  logic [STAGES-1:0] dirtyClr;
  logic [DW-1:0] statusSet;
  logic [DW-1:0] statusClr;

  always_ff @(posedge clk) begin
    if (srst) begin
      p2Valid <= 1'b0;
      p2Stage <= '0;
      p2Data <= '0;
    end else begin
      p2Valid <= p1Valid;
      p2Stage <= p1Stage;
      p2Data <= p1Data;
    end
  end

  // converted stage first; a software-edited stage waits for a free cycle
  assign trSel = p2Valid ? p2Stage : firstSet(dirty);

  act_trip uTrip (
    .ambient(ambient[trSel]),
    .upperOfs(upperOfs[trSel]),
    .lowerOfs(lowerOfs[trSel]),
    .posCode(sensCfg[trSel][SENS_POS_LSB +: 4]),
    .upperTrip(newUpper),
    .lowerTrip(newLower)
  );

  always_comb begin
    hitHigh = p2Valid & (p2Data > newUpper);
    hitLow = p2Valid & (p2Data < newLower);
    dirtySet = '0;
    if (stageWr && (wslot <= SLOT_SENS)) begin
      dirtySet[ws] = 1'b1;
    end
    dirtyClr = '0;
    if (p2Valid || (dirty != '0)) begin
      dirtyClr[trSel] = 1'b1;
    end
    statusSet = '0;
    statusSet[p2Stage] = hitHigh;
    statusSet[STAGES + int'(p2Stage)] = hitLow;
    statusClr = (wrEn && (rb.idx == IDX_STATUS)) ? mergeBytes('0, rb.wdata, rb.be) : '0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int s = 0; s < STAGES; s++) begin
        upperTrip[s] <= '0;
        lowerTrip[s] <= '0;
      end
      dirty <= '0;
    end else begin
      if (p2Valid || (dirty != '0)) begin
        upperTrip[trSel] <= newUpper;
        lowerTrip[trSel] <= newLower;
      end
      dirty <= (dirty & ~dirtyClr) | dirtySet;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      touched <= '0;
      stageActive <= '0;
      statusReg <= '0;
    end else begin
      if (p2Valid) begin
        touched[p2Stage] <= hitHigh | hitLow;
      end
      stageActive <= touched;
      statusReg <= (statusReg & ~statusClr) | statusSet;
    end
  end
endmodule // act_cal_top

// file: inc/act_pkg.sv
// constants, types and shared arithmetic for the ambient calibration block
package act_pkg;
  localparam int STAGES = 8;
  localparam int STAGE_W = 3;
  localparam int DW = 16;
  localparam int CW = 20;
  localparam int IDX_W = 7;
  localparam int ADDR_W = 9;
  localparam int SLOW_DEPTH = 4;
  localparam int SLOW_DEPTH_LOG = 2;
  localparam int SKIP_CNT_W = 8;

  localparam logic [IDX_W-1:0] IDX_CTRL = 7'h00;
  localparam logic [IDX_W-1:0] IDX_SKIP = 7'h01;
  localparam logic [IDX_W-1:0] IDX_PUSH = 7'h03;
  localparam logic [IDX_W-1:0] IDX_STATUS = 7'h04;
  localparam logic [IDX_W-1:0] IDX_STAGE_BASE = 7'h40;

  localparam logic [2:0] SLOT_UPPER_OFS = 3'h0;
  localparam logic [2:0] SLOT_LOWER_OFS = 3'h1;
  localparam logic [2:0] SLOT_SENS = 3'h2;
  localparam logic [2:0] SLOT_AMBIENT = 3'h3;
  localparam logic [2:0] SLOT_UPPER_TRIP = 3'h4;
  localparam logic [2:0] SLOT_LOWER_TRIP = 3'h5;
  localparam logic [2:0] SLOT_AVG_MAX = 3'h6;
  localparam logic [2:0] SLOT_AVG_MIN = 3'h7;

  localparam int CTRL_SFEN_BIT = 0;
  localparam int CTRL_LP_BIT = 1;
  localparam int CTRL_FF_LSB = 4;
  localparam int CTRL_DLY_LSB = 8;
  localparam int SKIP_FP_LSB = 12;
  localparam int SKIP_LP_LSB = 14;
  localparam int PUSH_LVL_LSB = 14;
  localparam int SENS_POS_LSB = 0;
  localparam int SENS_NEG_LSB = 4;
  localparam int SENS_PPK_LSB = 8;
  localparam int SENS_NPK_LSB = 12;

  localparam logic [DW-1:0] CTRL_RST = 16'h0001;
  localparam logic [DW-1:0] SKIP_RST = 16'h0000;
  localparam logic [DW-1:0] PUSH_RST = 16'h0000;
  localparam logic [DW-1:0] SENS_RST = 16'h0000;

  localparam int QUARTER_SH = 2;
  localparam int SIXTEENTH_SH = 4;
  localparam int PEAK_SH = 4;
  localparam int AVG_SH = 1;

  localparam logic signed [CW-1:0] SAT_HI = 20'sh0FFFF;
  localparam logic signed [CW-1:0] SOFS_HI = 20'sh07FFF;
  localparam logic signed [CW-1:0] SOFS_LO = -20'sh08000;

  typedef enum logic [1:0] {
    ACT_IDLE = 2'b00,
    ACT_ISSUE = 2'b01,
    ACT_ANSWER = 2'b10
  } act_bus_state_t;

  // shift that rounds negatives toward zero, unlike a bare arithmetic shift
  function automatic logic signed [CW-1:0] act_div_pow2(input logic signed [CW-1:0] v,
                                                        input int sh);
    logic signed [CW-1:0] bias;
    bias = (v < 0) ? ((CW'(1) << sh) - CW'(1)) : '0;
    return (v + bias) >>> sh;
  endfunction

  function automatic logic [DW-1:0] act_sat_u16(input logic signed [CW-1:0] v);
    if (v < 0) return '0;
    if (v > SAT_HI) return 16'hFFFF;
    return v[DW-1:0];
  endfunction

  function automatic logic signed [DW-1:0] act_sat_s16(input logic signed [CW-1:0] v);
    if (v < SOFS_LO) return 16'sh8000;
    if (v > SOFS_HI) return 16'sh7FFF;
    return v[DW-1:0];
  endfunction
endpackage

// file: inc/act_reg_if.sv
// register strobe carrier between the bus slave and the calibration core
`timescale 1ns/1ps
interface act_reg_if;
  import act_pkg::*;
  logic go;
  logic we;
  logic [1:0] be;
  logic [IDX_W-1:0] idx;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport bus (output go, output we, output be, output idx, output wdata, input rdata);
  modport core (input go, input we, input be, input idx, input wdata, output rdata);
endinterface

// file: logic/act_bus.sv
// avalon-mm slave with waitrequest, turned into a one-cycle register strobe
`timescale 1ns/1ps
module act_bus (
  input wire logic clk,
  input wire logic srst,
  input wire logic [act_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  act_reg_if.bus rb
);
  import act_pkg::*;
  act_bus_state_t state;

  // fixed three-edge handshake; waitrequest idles high so no request slips by
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ACT_IDLE;
      waitrequest <= 1'b1;
      readdata <= '0;
      rb.go <= 1'b0;
      rb.we <= 1'b0;
      rb.be <= '0;
      rb.idx <= '0;
      rb.wdata <= '0;
    end else begin
      case (state)
        ACT_IDLE: begin
          if (read || write) begin
            rb.go <= 1'b1;
            rb.we <= write;
            rb.be <= byteenable[1:0];
            rb.idx <= address[ADDR_W-1:2];
            rb.wdata <= writedata[DW-1:0];
            state <= ACT_ISSUE;
          end
        end
        ACT_ISSUE: begin
          rb.go <= 1'b0;
          waitrequest <= 1'b0;
          readdata <= {16'h0000, rb.rdata};
          state <= ACT_ANSWER;
        end
        ACT_ANSWER: begin
          waitrequest <= 1'b1;
          state <= ACT_IDLE;
        end
        default: begin
          rb.go <= 1'b0;
          waitrequest <= 1'b1;
          state <= ACT_IDLE;
        end
      endcase
    end
  end
endmodule // act_bus

// file: logic/act_trip.sv
// trip level arithmetic for one stage
`timescale 1ns/1ps
module act_trip (
  input wire logic [act_pkg::DW-1:0] ambient,
  input wire logic signed [act_pkg::DW-1:0] upperOfs,
  input wire logic signed [act_pkg::DW-1:0] lowerOfs,
  input wire logic [3:0] posCode,
  output logic [act_pkg::DW-1:0] upperTrip,
  output logic [act_pkg::DW-1:0] lowerTrip
);
  import act_pkg::*;
  logic signed [CW-1:0] amb;
  logic signed [CW-1:0] uo;
  logic signed [CW-1:0] lo;
  logic signed [CW-1:0] uq;
  logic signed [CW-1:0] ur;
  logic signed [CW-1:0] lq;
  logic signed [CW-1:0] code;

  // upper trip: code 8 lands at 62.5% of the offset, code 15 at 95.3%; lower trip: code 8 at 225%, code 15 at 400%
  always_comb begin
    amb = CW'(ambient);
    uo = CW'(upperOfs);
    lo = CW'(lowerOfs);
    code = CW'(posCode);
    uq = act_div_pow2(uo, QUARTER_SH);
    ur = act_div_pow2(uo - uq, SIXTEENTH_SH);
    lq = act_div_pow2(lo, QUARTER_SH);
    upperTrip = act_sat_u16(amb + uq + CW'(ur * code));
    lowerTrip = act_sat_u16(amb + lq + CW'(lq * code));
  end
endmodule // act_trip

// file: verification/act_conv_model.sv
// converter stage-result source facing the calibration block
`timescale 1ns/1ps
module act_conv_model (
  input wire logic clk,
  output logic convValid,
  output logic [act_pkg::STAGE_W-1:0] convStage,
  output logic [act_pkg::DW-1:0] convData,
  output logic proximity
);
  import act_pkg::*;
  initial begin
    convValid = 1'b0;
    convStage = '0;
    convData = '0;
    proximity = 1'b0;
  end
  // one-cycle result; data scrambled after so no stale value looks valid
  // proximity is a level: it stays until the next result sets it again
  task automatic convert(input logic [STAGE_W-1:0] s, input logic [DW-1:0] d, input logic p);
    @(posedge clk);
    convValid <= 1'b1;
    convStage <= s;
    convData <= d;
    proximity <= p;
    @(posedge clk);
    convValid <= 1'b0;
    convData <= ~d;
  endtask
endmodule // act_conv_model

// file: verification/act_cal_top_assertions.sv
// port timing checker for the calibration block
`timescale 1ns/1ps
module act_cal_top_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic [act_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic convValid,
  input wire logic [act_pkg::STAGE_W-1:0] convStage,
  input wire logic [act_pkg::STAGES-1:0] stageActive
);
  import act_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence reqSeen;
    $rose(avs_read || avs_write);
  endsequence
  sequence answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  AST_ANSWER_TWO: assert property (reqSeen |=> answer)
    else $error("bus answer not two cycles after request");
  AST_ONE_LOW: assert property (!avs_waitrequest |=> avs_waitrequest [*2])
    else $error("waitrequest low too long");
  AST_UNASKED: assert property (!avs_waitrequest |-> $past(avs_read || avs_write, 2))
    else $error("answer without request");
  AST_HIGH_ZERO: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_UNMAPPED: assert property (!avs_waitrequest && avs_read && avs_address[8:2] == 7'h02
    |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  AST_RESET_QUIET: assert property ($fell(srst) |-> avs_waitrequest && stageActive == 8'h00)
    else $error("outputs not quiet after reset");
  AST_ACTIVE_LATE: assert property ($changed(stageActive) |-> $past(convValid, 4))
    else $error("contact flags moved without conversion");
  AST_ONLY_STAGE: assert property ($changed(stageActive) |->
    ((stageActive ^ $past(stageActive)) & ~(8'h01 << $past(convStage, 4))) == 8'h00)
    else $error("contact flag of another stage moved");
endmodule // act_cal_top_assertions

bind act_cal_top act_cal_top_assertions chk (.clk(clk), .srst(srst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .convValid(convValid), .convStage(convStage), .stageActive(stageActive));

// file: verification/act_cal_top_bench.sv
// self-checking bench for the calibration block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module act_cal_top_bench;
  import act_pkg::*;
  logic clk, srst, avs_read, avs_write, avs_waitrequest, convValid, proximity;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, expRead;
  logic [3:0] avs_byteenable;
  logic [STAGE_W-1:0] convStage;
  logic [DW-1:0] convData;
  logic [STAGES-1:0] stageActive;
  logic [31:0] expQ[$];
  int failures = 0, check_count = 0, cycles = 0, seed = 60;
  act_cal_top uut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .convValid(convValid),
    .convStage(convStage), .convData(convData), .proximity(proximity),
    .stageActive(stageActive));
  act_conv_model conv (.clk(clk), .convValid(convValid), .convStage(convStage),
    .convData(convData), .proximity(proximity));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // whole run needs about 400 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  always @(posedge clk) begin
    if (avs_waitrequest === 1'b0 && avs_read === 1'b1) begin
      expRead = expQ.pop_front();
      `CHK(avs_readdata, expRead)
    end
  end
  task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [DW-1:0] d);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [DW-1:0] e);
    expQ.push_back({16'h0000, e});
    bus(1'b0, idx, 16'h0000);
  endtask
  function automatic logic [IDX_W-1:0] sa(input logic [2:0] s, input logic [2:0] k);
    return IDX_STAGE_BASE | {1'b0, s, k};
  endfunction
  // trip level with ambient at zero; int division truncates toward zero
  function automatic logic [DW-1:0] trip(input logic signed [DW-1:0] o, input logic [3:0] c,
                                         input bit up);
    int q, v;
    q = o / 4;
    v = q + (up ? (o - q) / 16 : q) * c;
    return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hFFFF : v[15:0];
  endfunction
  initial begin
    logic [2:0] s;
    logic signed [DW-1:0] uo, lo;
    srst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(IDX_CTRL, 16'h0001);
    rd(IDX_SKIP, 16'h0000);
    rd(IDX_PUSH, 16'h0000);
    rd(7'h02, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, IDX_SKIP, {i[1:0], ~i[1:0], 12'h000});
      rd(IDX_SKIP, {i[1:0], ~i[1:0], 12'h000});
      bus(1'b1, IDX_PUSH, {i[1:0], 14'h0000});
      rd(IDX_PUSH, {i[1:0], 14'h0000});
    end
    $display("test registers done");
    s = 3'($random(seed));
    uo = DW'($random(seed)) & 16'h0FFF;
    lo = DW'($random(seed)) & 16'h0FFF;
    bus(1'b1, sa(s, SLOT_UPPER_OFS), uo);
    bus(1'b1, sa(s, SLOT_LOWER_OFS), lo);
    rd(sa(s, SLOT_AVG_MAX), uo);
    rd(sa(s, SLOT_AVG_MIN), lo);
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, sa(s, SLOT_SENS), {12'h000, 4'(c)});
      rd(sa(s, SLOT_UPPER_TRIP), trip(uo, 4'(c), 1'b1));
      rd(sa(s, SLOT_LOWER_TRIP), trip(lo, 4'(c), 1'b0));
    end
    $display("test trip levels done");
    bus(1'b1, sa(s, SLOT_LOWER_OFS), 16'h0000);
    bus(1'b1, sa(s, SLOT_SENS), 16'h0000);
    conv.convert(s, 16'hFFFF, 1'b0);
    repeat (3) @(posedge clk);
    #1 `CHK(stageActive, 8'h01 << s)
    conv.convert(s + 3'd1, 16'h0000, 1'b0);
    repeat (3) @(posedge clk);
    #1 `CHK(stageActive, 8'h01 << s)
    rd(IDX_STATUS, {8'h00, 8'h01 << s});
    bus(1'b1, IDX_STATUS, 16'h00FF);
    rd(IDX_STATUS, 16'h0000);
    $display("test contact done");
    // untouched stage: proximity must hold ambient, a clear push must move it
    bus(1'b1, sa(s + 3'd2, SLOT_UPPER_OFS), 16'h1000);
    conv.convert(s + 3'd2, 16'h0100, 1'b1);
    rd(sa(s + 3'd2, SLOT_AMBIENT), 16'h0000);
    conv.convert(s + 3'd2, 16'h0100, 1'b0);
    rd(sa(s + 3'd2, SLOT_AMBIENT), 16'h0040);
    rd(sa(s + 3'd2, SLOT_UPPER_OFS), 16'h0FC0);
    rd(sa(s + 3'd2, SLOT_UPPER_TRIP), 16'h0430);
    bus(1'b1, sa(s + 3'd2, SLOT_SENS), 16'h0F00);
    conv.convert(s + 3'd2, 16'h0200, 1'b1);
    rd(sa(s + 3'd2, SLOT_AVG_MAX), 16'h0900);
    rd(sa(s + 3'd2, SLOT_UPPER_TRIP), 16'h0270);
    $display("test ambient done");
    // full power then low power, both set to a period of two conversions
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, IDX_CTRL, m ? 16'h0003 : 16'h0001);
      bus(1'b1, IDX_SKIP, m ? 16'h4000 : 16'h2000);
      bus(1'b1, sa(s + 3'(m + 3), SLOT_UPPER_OFS), 16'h1000);
      conv.convert(s + 3'(m + 3), 16'h0100, 1'b0);
      rd(sa(s + 3'(m + 3), SLOT_AMBIENT), 16'h0000);
      conv.convert(s + 3'(m + 3), 16'h0100, 1'b0);
      rd(sa(s + 3'(m + 3), SLOT_AMBIENT), 16'h0040);
    end
    $display("test skip period done");
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule // act_cal_top_bench
